// File: include/sbe_pkg.sv
// Purpose: constants and types for the serial bus eeprom slave
// Assumes: core clock 10 MHz, bus clock a separate domain
// Notes: bus addresses and special locations as hex figures
package sbe_pkg;
    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned PROG_TIME_MS = 10;
    localparam int unsigned PROG_CYCLES = (CLK_HZ / 1000) * PROG_TIME_MS;
    localparam logic [7:0] BUS_ADDR_LOAD = 8'h80;
    localparam logic [7:0] BUS_ADDR_READ = 8'h81;
    localparam logic [7:0] BUS_ADDR_PROG = 8'h83;
    localparam logic [7:0] BUS_ADDR_OPT_OFS = 8'h04;
    localparam logic [9:0] USER_LAST = 10'h1ff;
    localparam logic [9:0] TEST_CONTROL_BYTE_OFS = 10'h204;
    localparam logic [9:0] PROGRAM_STATUS_OFS = 10'h20e;
    localparam logic [7:0] TEST_CONTROL_BYTE_RST = 8'h00;
    localparam int unsigned BUSY_BIT = 1;
    localparam int unsigned TB_BLOCK = 7;
    localparam int unsigned TB_ENABLE = 5;
    localparam int unsigned TB_PUMP_OFF = 3;
    localparam logic [5:0] PROT_MASK = 6'h30;

    typedef enum logic [1:0] {SBE_CMD_NONE, SBE_CMD_LOAD, SBE_CMD_READ, SBE_CMD_PROG} sbe_cmd_e;

    // one finished transaction, handed from bus domain to core
    typedef struct packed {
        sbe_cmd_e cmd;
        logic [15:0] data;
    } sbe_xact_s;

    // decoded test byte functions
    typedef struct packed {
        logic test_en;
        logic block_en;
        logic pump_off;
        logic [1:0] shift_neg;
        logic [1:0] shift_pos;
    } sbe_test_s;
endpackage

// File: rtl/sbe_top.sv
// Purpose: slave logic of a 512x8 eeprom on a three-wire serial bus
// Assumes: bus clock pin clocks the shift logic; core clock times programming
// Notes: the array is modelled as flops; analog functions appear as outputs
// Notes: bus shifting runs on the bus clock pin, the end pulse on the frame select
//        edge; the core clock times programming, holds the address and test byte, and owns the array
`timescale 1ns/1ps
module sbe_top #(
    parameter int unsigned PROG_CNT = sbe_pkg::PROG_CYCLES
) (
    // core clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial bus
    input wire logic serial_bus_clock,
    input wire logic frame_select,
    input wire logic data_in,
    output logic data_out,
    output logic data_oe,
    // straps
    input wire logic option_pin,
    input wire logic safe_in,
    // test functions and status
    output sbe_pkg::sbe_test_s test_out,
    output logic busy
);
    import sbe_pkg::*;

    // the timer is 24 bits wide and needs at least two counts to show busy
    initial begin
        if (PROG_CNT < 2) begin
            $error("PROG_CNT below two cycles");
        end
        if (PROG_CNT > 32'h00ffffff) begin
            $error("PROG_CNT beyond the 24-bit timer");
        end
    end

    // reset release for the core domain; assertion is immediate, release waits two edges
    // so that no core flop leaves reset in the cycle the pin rises
    logic rst_s1_q;
    logic rst_s2_q;
    logic rsync_n;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rsync_n = rst_s2_q;

    // ---------------- bus clock domain ----------------
    // the raw reset pin clears the bus logic, aborting a transfer at once
    // no timer here: the link clock may stop, so any pause is harmless
    logic [4:0] bcnt_q;
    logic [15:0] sh_q;
    logic [7:0] baddr_q;
    logic in_data_q;
    logic dph_tog_q;
    logic [1:0] opt_sync_q;
    logic opt_s;
    logic [7:0] rd_byte;
    logic [7:0] opt_ofs;
    logic [7:0] ld_code;
    logic [7:0] rd_code;
    logic [7:0] pg_code;
    logic addr_ld;
    logic addr_rd;
    logic addr_pg;

    // option strap is a pin: two bus clock flops before the decode reads it
    // it is meant to be tied, so settling over the eight address clocks is enough
    always_ff @(posedge serial_bus_clock or negedge rst_n) begin
        if (!rst_n) begin
            opt_sync_q <= 2'b00;
        end else begin
            opt_sync_q <= {opt_sync_q[0], option_pin};
        end
    end
    assign opt_s = opt_sync_q[1];

    // option pin shifts the three addresses by four
    assign opt_ofs = opt_s ? BUS_ADDR_OPT_OFS : 8'h00;
    assign ld_code = BUS_ADDR_LOAD + opt_ofs;
    assign rd_code = BUS_ADDR_READ + opt_ofs;
    assign pg_code = BUS_ADDR_PROG + opt_ofs;
    // compare against the received address byte
    assign addr_ld = baddr_q == ld_code;
    assign addr_rd = baddr_q == rd_code;
    assign addr_pg = baddr_q == pg_code;

    // bits taken on the rising edge, lsb first
    always_ff @(posedge serial_bus_clock or negedge rst_n) begin
        if (!rst_n) begin
            bcnt_q <= 5'h00;
            sh_q <= 16'h0000;
            baddr_q <= 8'h00;
            in_data_q <= 1'b0;
            dph_tog_q <= 1'b0;
        end else if (!frame_select) begin
            // address phase: first clock of a frame restarts the count
            if (in_data_q) begin
                bcnt_q <= 5'h01;
                in_data_q <= 1'b0;
            end else begin
                bcnt_q <= bcnt_q + 5'h01;
            end
            baddr_q <= {data_in, baddr_q[7:1]};
        end else begin
            // data phase after frame select returned high
            if (!in_data_q) begin
                // first data clock of the frame marks a fresh data phase for the end pulse
                bcnt_q <= 5'h01;
                dph_tog_q <= ~dph_tog_q;
            end else begin
                bcnt_q <= bcnt_q + 5'h01;
            end
            in_data_q <= 1'b1;
            sh_q <= {data_in, sh_q[15:1]};
        end
    end

    // end pulse on frame select: low pulse after data, latched on the pin itself
    // a short end pulse may carry no clock, so it is caught asynchronously
    // the next frame also opens with a falling edge; the phase toggle compare keeps
    // that edge from committing the same transaction a second time
    logic end_tog_q;
    logic done_tog_q;
    logic fresh_phase;
    logic [15:0] xdata_q;
    sbe_cmd_e xcmd_q;
    sbe_cmd_e xcmd_d;
    assign fresh_phase = dph_tog_q != done_tog_q;
    // command chosen from the address byte of the frame being closed
    assign xcmd_d = addr_ld ? SBE_CMD_LOAD :
                    addr_pg ? SBE_CMD_PROG :
                    addr_rd ? SBE_CMD_READ : SBE_CMD_NONE;
    always_ff @(negedge frame_select or negedge rst_n) begin
        if (!rst_n) begin
            end_tog_q <= 1'b0;
            done_tog_q <= 1'b0;
            xdata_q <= 16'h0000;
            xcmd_q <= SBE_CMD_NONE;
        end else if (fresh_phase) begin
            end_tog_q <= ~end_tog_q;
            done_tog_q <= dph_tog_q;
            xdata_q <= sh_q;
            xcmd_q <= xcmd_d;
        end
    end

    // read data: each bit's pull-down is set on the falling clock ahead of the rising
    // edge at which the master takes it; bit 0 leaves on the first falling edge of
    // the data phase, before the count has restarted
    logic doe_q;
    logic rd_phase;
    logic [2:0] rd_idx;
    logic rd_bit;
    assign rd_phase = frame_select && addr_rd && (!in_data_q || bcnt_q < 5'd8);
    assign rd_idx = in_data_q ? bcnt_q[2:0] : 3'd0;
    assign rd_bit = rd_byte[rd_idx];
    always_ff @(negedge serial_bus_clock or negedge rst_n) begin
        if (!rst_n) begin
            doe_q <= 1'b0;
        end else if (rd_phase) begin
            // open drain: pull only for a zero bit
            doe_q <= ~rd_bit;
        end else begin
            // released outside a matched read phase
            doe_q <= 1'b0;
        end
    end
    // open drain: the level is always low, only the enable moves
    assign data_out = 1'b0;
    assign data_oe = doe_q;

    // ---------------- core domain ----------------
    // the end toggle crosses on two flops; a third gives the edge, one pulse per frame
    // the command and data words were written on the same edge as the toggle, so they stand
    logic [2:0] tog_sync_q;
    logic end_evt;
    always_ff @(posedge clk or negedge rsync_n) begin
        if (!rsync_n) begin
            tog_sync_q <= 3'b000;
        end else begin
            tog_sync_q <= {tog_sync_q[1:0], end_tog_q};
        end
    end
    assign end_evt = tog_sync_q[2] ^ tog_sync_q[1];

    // safe strap is a pin as well: two core flops before the protection check
    logic [1:0] safe_sync_q;
    logic safe_s;
    always_ff @(posedge clk or negedge rsync_n) begin
        if (!rsync_n) begin
            safe_sync_q <= 2'b00;
        end else begin
            safe_sync_q <= {safe_sync_q[0], safe_in};
        end
    end
    assign safe_s = safe_sync_q[1];

    // memory address register survives reset: no reset branch
    logic [9:0] mar_q;
    logic busy_q;
    logic mar_we;
    // a load frame while busy is dropped and the old address stands
    assign mar_we = end_evt && xcmd_q == SBE_CMD_LOAD && !busy_q;
    always_ff @(posedge clk) begin
        if (mar_we) begin
            mar_q <= xdata_q[9:0];
        end
    end

    // programming state
    typedef enum logic [0:0] {
        SBE_IDLE,
        SBE_PROG
    } sbe_state_e;
    sbe_state_e st_q;
    // cycle timer, loaded with the count less one and run down to zero
    logic [23:0] tmr_q;
    logic [7:0] pdata_q;
    logic [9:0] paddr_q;
    logic pblock_q;
    logic [7:0] tbyte_q;
    // 512 cells of one byte each
    logic [7:0] mem_q [0:511];
    logic start_prog;
    logic start_test;
    logic start_cell;

    // discarded while busy
    assign start_prog = end_evt && xcmd_q == SBE_CMD_PROG && st_q == SBE_IDLE;
    // 516 takes the test byte at once and starts no timed cycle
    assign start_test = start_prog && mar_q == TEST_CONTROL_BYTE_OFS;
    // only user locations start a cycle; other special locations drop the command
    assign start_cell = start_prog && mar_q <= USER_LAST;

    always_ff @(posedge clk or negedge rsync_n) begin
        if (!rsync_n) begin
            st_q <= SBE_IDLE; // aborts a running cycle
            tmr_q <= 24'h000000;
            pdata_q <= 8'h00;
            paddr_q <= 10'h000;
            pblock_q <= 1'b0;
            tbyte_q <= TEST_CONTROL_BYTE_RST;
            busy_q <= 1'b0;
        end else begin
            case (st_q)
                SBE_IDLE: begin
                    if (start_test) begin
                        tbyte_q <= xdata_q[7:0];
                    end else if (start_cell) begin
                        st_q <= SBE_PROG;
                        busy_q <= 1'b1;
                        tmr_q <= PROG_CNT[23:0] - 24'h000001;
                        pdata_q <= xdata_q[7:0]; // upper byte dropped
                        paddr_q <= mar_q;
                        pblock_q <= tbyte_q[TB_BLOCK] && tbyte_q[TB_ENABLE] && !mar_q[9];
                    end
                end
                SBE_PROG: begin
                    // bus frames cannot disturb the timed cycle; only reset cuts it short
                    // the array is written in the last cycle by the select logic below
                    if (tmr_q == 24'h000000) begin
                        st_q <= SBE_IDLE;
                        busy_q <= 1'b0;
                    end else begin
                        tmr_q <= tmr_q - 24'h000001;
                    end
                end
                default: st_q <= SBE_IDLE;
            endcase
        end
    end

    // array write at the end of the cycle, single or block
    // one select bit per byte, so the whole block lands in the same clock
    logic prog_done;
    logic [511:0] wsel;
    assign prog_done = st_q == SBE_PROG && tmr_q == 24'h000000;
    for (genvar g = 0; g < 512; g++) begin : g_sel
        localparam logic [9:0] GA = 10'(g);
        logic blk_hit;
        logic one_hit;
        logic prot_ok;
        // block mode: bit 1 clear takes all bytes, else bit 0 picks even or odd
        assign blk_hit = pblock_q && (!paddr_q[1] || GA[0] == paddr_q[0]);
        assign one_hit = !pblock_q && GA[8:0] == paddr_q[8:0];
        // lowest sixteen of each 64 block skipped without the safe strap
        assign prot_ok = (GA[5:0] & PROT_MASK) != 6'h00 || safe_s;
        assign wsel[g] = prog_done && (blk_hit || one_hit) && prot_ok;
    end
    // the array has no reset: contents survive like the cells they model
    always_ff @(posedge clk) begin
        for (int i = 0; i < 512; i++) begin
            if (wsel[i]) begin
                mem_q[i] <= pdata_q;
            end
        end
    end

    // read mux; only the status location is trustworthy while busy
    logic is_status;
    logic is_test;
    logic is_user;
    logic [7:0] status_byte;
    logic [7:0] user_byte;
    logic [7:0] rd_core;
    assign is_status = mar_q == PROGRAM_STATUS_OFS;
    assign is_test = mar_q == TEST_CONTROL_BYTE_OFS;
    assign is_user = mar_q <= USER_LAST;
    // busy sits in bit 1 of the status location
    assign status_byte = {6'h00, busy_q, 1'b0};
    assign user_byte = mem_q[mar_q[8:0]];
    // unused locations read as erased cells
    assign rd_core = is_status ? status_byte :
                     is_test ? tbyte_q :
                     is_user ? user_byte : 8'hff;
    // read byte used by the bus clock domain; it stands still from the load frame
    // on, long before the read frame shifts it, so no handshake is needed
    assign rd_byte = rd_core;

    // test functions decoded from the test byte
    // every function is gated by the enable bit, so a stray byte stays harmless
    logic tb_en;
    sbe_test_s test_d;
    sbe_test_s test_q;
    assign tb_en = tbyte_q[TB_ENABLE];
    assign test_d.test_en = tb_en;
    assign test_d.block_en = tbyte_q[TB_BLOCK] & tb_en;
    assign test_d.pump_off = tbyte_q[TB_PUMP_OFF] & tb_en;
    // two negative and two positive reference steps
    assign test_d.shift_neg = {tbyte_q[4], tbyte_q[6]} & {2{tb_en}};
    assign test_d.shift_pos = {tbyte_q[0], tbyte_q[2]} & {2{tb_en}};
    always_ff @(posedge clk or negedge rsync_n) begin
        if (!rsync_n) begin
            test_q <= '0;
        end else begin
            test_q <= test_d;
        end
    end
    assign test_out = test_q;
    assign busy = busy_q;
endmodule

// File: verification/sbe_top_checker.sv
// Purpose: port checks for the eeprom slave
// Assumes: PROG_CNT equals the value given to the design
// Notes: bound into sbe_top at the foot of this file
`timescale 1ns/1ps
module sbe_top_checker #(
    parameter int unsigned PROG_CNT = 20
) (
    // core
    input wire logic clk,
    input wire logic rst_n,
    // bus
    input wire logic serial_bus_clock,
    input wire logic frame_select,
    input wire logic data_in,
    input wire logic data_out,
    input wire logic data_oe,
    // straps and status
    input wire logic option_pin,
    input wire logic safe_in,
    input wire sbe_pkg::sbe_test_s test_out,
    input wire logic busy
);
    import sbe_pkg::*;
    logic [15:0] run_q;
    logic [7:0] idle_q;
    // busy run length, and cycles since frame select was last seen low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= '0;
            idle_q <= '0;
        end else begin
            run_q <= busy ? run_q + 16'h1 : 16'h0;
            idle_q <= !frame_select ? 8'h0 : idle_q + {7'h0, idle_q != 8'hff};
        end
    end
    property p_busy_len; @(posedge clk) disable iff (!rst_n)
        $fell(busy) |-> run_q == PROG_CNT; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length off");
    property p_busy_min; @(posedge clk) disable iff (!rst_n)
        $rose(busy) |=> busy [*8]; endproperty
    a_busy_min: assert property (p_busy_min) else $error("busy too short");
    property p_busy_go; @(posedge clk) disable iff (!rst_n)
        $rose(busy) |-> frame_select && idle_q <= 8'd6; endproperty
    a_busy_go: assert property (p_busy_go) else $error("busy not from end pulse");
    property p_test_go; @(posedge clk) disable iff (!rst_n)
        $changed(test_out) |-> idle_q <= 8'd6; endproperty
    a_test_go: assert property (p_test_go) else $error("test byte moved alone");
    property p_rst_clr; @(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> !busy && test_out == '0; endproperty
    a_rst_clr: assert property (p_rst_clr) else $error("reset left state");
    property p_oe_addr; @(posedge serial_bus_clock) disable iff (!rst_n)
        !frame_select |-> !data_oe; endproperty
    a_oe_addr: assert property (p_oe_addr) else $error("drive in address");
    property p_od; @(posedge clk) disable iff (!rst_n)
        data_oe |-> !data_out && !data_in; endproperty
    a_od: assert property (p_od) else $error("line not pulled low");
    property p_oe_busy; @(posedge clk) disable iff (!rst_n)
        $rose(busy) |-> !data_oe [*2]; endproperty
    a_oe_busy: assert property (p_oe_busy) else $error("drive at end pulse");
    c_done: cover property (@(posedge clk) $fell(busy));
    c_read: cover property (@(posedge clk) data_oe);
    c_block: cover property (@(posedge clk) test_out.block_en);
endmodule
bind sbe_top sbe_top_checker #(.PROG_CNT(PROG_CNT)) u_chk (.clk(clk), .rst_n(rst_n),
    .serial_bus_clock(serial_bus_clock), .frame_select(frame_select), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .option_pin(option_pin), .safe_in(safe_in),
    .test_out(test_out), .busy(busy));

// File: verification/sbe_master.sv
// Purpose: serial bus master model for the eeprom slave
// Assumes: pull-up on data; bus clock stands high between frames
// Notes: xact sends address byte then a 16-bit word, lsb first
`timescale 1ns/1ps
module sbe_master (
    // bus lines
    output logic serial_bus_clock,
    output logic frame_select,
    output logic data_in,
    // slave pull-down
    input wire logic data_oe
);
    logic drv = 1'b1;
    // open drain: high unless a party pulls low
    assign data_in = drv & !data_oe;
    initial begin
        serial_bus_clock = 1'b1;
        frame_select = 1'b1;
    end
    // bit set while clock low, taken at the rising edge
    task automatic bit_t(input logic b, output logic r);
        serial_bus_clock = 1'b0;
        drv = b;
        #3;
        serial_bus_clock = 1'b1;
        r = data_in;
        #3;
    endtask
    task automatic xact(input logic [7:0] a, input logic [15:0] w, output logic [15:0] r);
        logic x;
        frame_select = 1'b0;
        for (int i = 0; i < 8; i++) bit_t(a[i], x);
        frame_select = 1'b1;
        for (int i = 0; i < 16; i++) bit_t(w[i], r[i]);
        drv = 1'b1;
        frame_select = 1'b0;
        #100;
        frame_select = 1'b1;
        #600;
    endtask
endmodule

// File: verification/test_serial_bus_eeprom_slave.sv
// Purpose: self-checking bench for the eeprom slave
// Assumes: 100 ns core clock, programming shortened to 60 clocks
// Notes: fixed seed, so every run repeats
`timescale 1ns/1ps
module test_serial_bus_eeprom_slave;
    import sbe_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic option_pin = 1'b0;
    logic safe_in = 1'b0;
    wire logic serial_bus_clock, frame_select, data_in, data_out, data_oe, busy;
    sbe_test_s test_out;
    int failures = 0;
    int total_checks = 0;
    int seed = 27102;
    int cyc = 0;
    logic [7:0] ofs = 8'h00;
    logic [15:0] rd_q;
    logic [9:0] a;
    logic [7:0] d, t;
    logic s;
    always #50 clk = ~clk;
    sbe_top #(.PROG_CNT(60)) dut (.clk(clk), .rst_n(rst_n), .serial_bus_clock(serial_bus_clock),
        .frame_select(frame_select), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .option_pin(option_pin), .safe_in(safe_in), .test_out(test_out), .busy(busy));
    sbe_master u_m (.serial_bus_clock(serial_bus_clock), .frame_select(frame_select),
        .data_in(data_in), .data_oe(data_oe));
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h want %h", $time, got, exp);
        end
    endtask
    // protected unless safe is high or address bits 5:4 are nonzero
    function automatic logic ok(input logic [9:0] x, input logic sf);
        return sf || x[5:4] != 2'b00;
    endfunction
    task automatic bus(input logic [7:0] c, input logic [15:0] w);
        u_m.xact(c + ofs, w, rd_q);
    endtask
    task automatic load(input logic [9:0] x);
        bus(BUS_ADDR_LOAD, {6'h0, x});
    endtask
    // waits for the cycle to start and end unless asked not to
    task automatic prog(input logic [15:0] w, input bit wt = 1'b1);
        bus(BUS_ADDR_PROG, w);
        if (wt) for (int i = 0; i < 200 && (busy !== 1'b0 || i < 6); i++) @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] exp);
        bus(BUS_ADDR_READ, 16'hffff);
        chk(rd_q[7:0], exp);
    endtask
    task automatic rst;
        @(posedge clk) rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        // boundary then random locations: erase, write with safe varied
        for (int i = 0; i < 5; i++) begin
            a = i == 0 ? 10'd15 : i == 1 ? 10'd16 : 10'($random(seed)) & 10'h1ff;
            s = i == 0 ? 1'b0 : 1'($random(seed));
            d = 8'($random(seed));
            @(posedge clk) safe_in <= 1'b1;
            load(a);
            prog(16'h00ff);
            @(posedge clk) safe_in <= s;
            prog({8'($random(seed)), d});
            rd(ok(a, s) ? d : 8'hff);
        end
        $display("locations done");
        // load and program during busy are dropped
        @(posedge clk) safe_in <= 1'b1;
        load(10'h1f0);
        prog(16'h00ff);
        prog(16'h005a, 0);
        chk({7'h0, busy}, 8'h01);
        load(10'h0f0);
        prog(16'h00a5);
        rd(8'h5a);
        load(PROGRAM_STATUS_OFS);
        bus(BUS_ADDR_READ, 16'hffff);
        chk({7'h0, rd_q[BUSY_BIT]}, 8'h00);
        $display("busy done");
        // test byte fields, enable bit forced, block bit kept off
        for (int i = 0; i < 4; i++) begin
            t = (8'($random(seed)) | 8'h20) & 8'h7f;
            load(TEST_CONTROL_BYTE_OFS);
            prog({8'h00, t});
            chk({5'h0, test_out.test_en, test_out.block_en, test_out.pump_off},
                {5'h0, t[5], t[7], t[3]});
            chk({7'h0, |test_out.shift_neg}, {7'h0, t[6] | t[4]});
            chk({7'h0, |test_out.shift_pos}, {7'h0, t[2] | t[0]});
        end
        // reset mid-cycle, then the address register outlives a reset
        load(10'h1f0);
        prog(16'h00ff, 0);
        rst();
        chk({7'h0, busy}, 8'h00);
        chk({1'b0, test_out}, 8'h00);
        load(10'h010);
        prog(16'h00ff);
        prog(16'h0033);
        rst();
        rd(8'h33);
        $display("test byte and reset done");
        // block programming: all bytes, then even, then odd
        load(TEST_CONTROL_BYTE_OFS);
        prog(16'h00a0);
        load(10'h000);
        prog(16'h00cc);
        rd(8'hcc);
        load(10'h002);
        prog(16'h0055);
        load(10'h003);
        prog(16'h00aa);
        load(TEST_CONTROL_BYTE_OFS);
        prog(16'h0000);
        for (int i = 0; i < 4; i++) begin
            a = 10'($random(seed)) & 10'h1ff;
            load(a);
            rd(a[0] ? 8'haa : 8'h55);
        end
        $display("block done");
        // option strap moves the device to the second address set
        @(posedge clk) option_pin <= 1'b1;
        bus(BUS_ADDR_READ, 16'hffff);
        chk(rd_q[7:0], 8'hff);
        ofs = BUS_ADDR_OPT_OFS;
        load(10'h011);
        rd(8'haa);
        $display("option done");
        wrap_up();
    end
endmodule
